// [avx_pkg.sv]
// avx_pkg: constants and carrier types for the accumulator/velocity/variable interpreter
// assumes a single 50 MHz clock domain
`default_nettype none
package avx_pkg;
    // ==========================================================
    // opcodes
    localparam logic [7:0] OP_ROT_DOWN  = 8'h32;
    localparam logic [7:0] OP_ROT_UP    = 8'h33;
    localparam logic [7:0] OP_STORE_IMM = 8'h37;
    localparam logic [7:0] OP_LOAD_VAR  = 8'h38;
    localparam logic [7:0] OP_STORE_ACC = 8'h39;
    localparam logic [7:0] OP_CUST_LO   = 8'h40;
    localparam logic [7:0] OP_CUST_HI   = 8'h47;
    // ==========================================================
    // reply status codes, frame layout
    localparam logic [7:0] ST_OK        = 8'h64;
    localparam logic [7:0] ST_BAD_CSUM  = 8'h01;
    localparam logic [7:0] ST_BAD_OP    = 8'h02;
    localparam int         FRAME_BYTES  = 9;
    localparam logic [7:0] HOST_ADDR    = 8'h02;
    localparam logic [7:0] MOD_ADDR_RST = 8'h01;
    // ==========================================================
    // axis parameter numbers and modes
    localparam logic [7:0] AP_TARGET_VEL = 8'h02;
    localparam int         VAR_DEPTH     = 256;
    localparam logic [31:0] ACC_RST      = 32'h0000_0000;
    localparam logic [31:0] IDX_RST      = 32'h0000_0000;

    typedef enum logic [1:0] {
        AVX_MODE_POSITION,
        AVX_MODE_VELOCITY
    } avx_mode_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  opcode;
        logic [7:0]  kind;
        logic [7:0]  bank;
        logic [31:0] value;
    } avx_cmd_t;

    typedef struct packed {
        logic [7:0]  status;
        logic [7:0]  opcode;
        logic [31:0] value;
    } avx_reply_t;

    typedef struct packed {
        avx_mode_t   mode;
        logic [7:0]  param;
        logic [31:0] value;
    } avx_axis_wr_t;
endpackage
`default_nettype wire

// [avx_var_bank.sv]
// avx_var_bank: 256-entry user variable bank, one write and one registered read port
// assumes index already range-checked by the caller
`default_nettype none
module avx_var_bank (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // write port
    input  wire logic        we_i,
    input  wire logic [7:0]  waddr_i,
    input  wire logic [31:0] wdata_i,
    // read port
    input  wire logic [7:0]  raddr_i,
    output logic      [31:0] rdata_o
);
    // ==========================================================
    // storage
    logic [31:0] mem_r [avx_pkg::VAR_DEPTH];

    // no reset on the array so it maps to ram; contents undefined until written
    always_ff @(posedge clk_i) begin
        if (we_i) begin
            mem_r[waddr_i] <= wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            rdata_o <= mem_r[raddr_i];
        end
    end
endmodule
`default_nettype wire

// [avx_interp.sv]
// avx_interp: byte-serial command interpreter for accumulator rotation and indexed variables
// assumes frames arrive one byte per valid cycle; reply bytes leave with valid/ready
`default_nettype none
module avx_interp (
    // clock and reset
    input  wire logic                clk_i,
    input  wire logic                rstn_i,
    // command byte stream
    input  wire logic                rx_valid_i,
    input  wire logic [7:0]          rx_data_i,
    output logic                     rx_ready_o,
    // reply byte stream
    output logic                     tx_valid_o,
    output logic      [7:0]          tx_data_o,
    input  wire logic                tx_ready_i,
    // shared interpreter state
    input  wire logic                acc_load_i,
    input  wire logic [31:0]         acc_load_val_i,
    input  wire logic                idx_load_i,
    input  wire logic [31:0]         idx_load_val_i,
    output logic      [31:0]         acc_o,
    output logic      [31:0]         idx_o,
    // axis parameter writes
    output logic                     axis_wr_o,
    output avx_pkg::avx_axis_wr_t    axis_o,
    output logic                     rot_down_o,
    // customer functions
    output logic                     cust_req_o,
    output avx_pkg::avx_cmd_t        cust_cmd_o,
    input  wire logic                cust_done_i,
    input  wire logic [31:0]         cust_value_i
);
    // ==========================================================
    // states
    typedef enum logic [2:0] {
        AVX_RX,
        AVX_EXEC,
        AVX_LOAD,
        AVX_CUST,
        AVX_TX
    } avx_state_t;

    avx_state_t           state_r;
    logic [3:0]           cnt_r;
    logic [7:0]           csum_r;
    logic [63:0]          frame_r;
    avx_pkg::avx_cmd_t    cmd;
    avx_pkg::avx_reply_t  rep_r;
    logic [7:0]           tx_sum_r;
    logic [31:0]          acc_r;
    logic [31:0]          idx_r;
    logic                 idx_ok;
    logic                 bank_we;
    logic [31:0]          bank_wdata;
    logic [31:0]          bank_rdata;

    assign cmd    = frame_r;
    // signed index: negative has msb set, anything over 255 has upper bits set
    assign idx_ok = (idx_r[31:8] == 24'h00_0000);
    assign acc_o  = acc_r;
    assign idx_o  = idx_r;
    assign rx_ready_o = (state_r == AVX_RX);
    assign tx_valid_o = (state_r == AVX_TX);

    // ==========================================================
    // frame reception
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r   <= 4'h0;
            csum_r  <= 8'h00;
            frame_r <= 64'h0;
        end else if (state_r == AVX_RX && rx_valid_i) begin
            if (cnt_r == 4'(avx_pkg::FRAME_BYTES - 1)) begin
                cnt_r  <= 4'h0;
                csum_r <= 8'h00;
            end else begin
                cnt_r   <= cnt_r + 4'h1;
                csum_r  <= csum_r + rx_data_i;
                frame_r <= {frame_r[55:0], rx_data_i};
            end
        end else if (state_r == AVX_TX && tx_ready_i && cnt_r == 4'(avx_pkg::FRAME_BYTES - 1)) begin
            cnt_r <= 4'h0;
        end else if (state_r == AVX_TX && tx_ready_i) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    // ==========================================================
    // control sequence
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= AVX_RX;
            rep_r   <= '0;
        end else begin
            case (state_r)
                AVX_RX: begin
                    if (rx_valid_i && cnt_r == 4'(avx_pkg::FRAME_BYTES - 1)) begin
                        rep_r.status <= (rx_data_i == csum_r) ? avx_pkg::ST_OK
                                                               : avx_pkg::ST_BAD_CSUM;
                        state_r      <= AVX_EXEC;
                    end
                end
                AVX_EXEC: begin
                    rep_r.opcode <= cmd.opcode;
                    rep_r.value  <= 32'h0000_0000;
                    if (rep_r.status != avx_pkg::ST_OK) begin
                        state_r <= AVX_TX;
                    end else if (cmd.opcode == avx_pkg::OP_LOAD_VAR && idx_ok) begin
                        state_r <= AVX_LOAD;
                    end else if (cmd.opcode >= avx_pkg::OP_CUST_LO
                                 && cmd.opcode <= avx_pkg::OP_CUST_HI) begin
                        state_r <= AVX_CUST;
                    end else begin
                        case (cmd.opcode)
                            avx_pkg::OP_ROT_DOWN, avx_pkg::OP_ROT_UP,
                            avx_pkg::OP_STORE_IMM, avx_pkg::OP_LOAD_VAR,
                            avx_pkg::OP_STORE_ACC: rep_r.status <= avx_pkg::ST_OK;
                            default:               rep_r.status <= avx_pkg::ST_BAD_OP;
                        endcase
                        state_r <= AVX_TX;
                    end
                end
                AVX_LOAD: state_r <= AVX_TX;
                AVX_CUST: begin
                    if (cust_done_i) begin
                        rep_r.status <= avx_pkg::ST_OK;
                        rep_r.value  <= cust_value_i;
                        state_r      <= AVX_TX;
                    end
                end
                AVX_TX: begin
                    if (tx_ready_i && cnt_r == 4'(avx_pkg::FRAME_BYTES - 1)) begin
                        state_r <= AVX_RX;
                    end
                end
                default: state_r <= AVX_RX;
            endcase
        end
    end

    // ==========================================================
    // accumulator and index registers
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            acc_r <= avx_pkg::ACC_RST;
        end else if (state_r == AVX_LOAD) begin
            acc_r <= bank_rdata;
        end else if (acc_load_i) begin
            acc_r <= acc_load_val_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            idx_r <= avx_pkg::IDX_RST;
        end else if (idx_load_i) begin
            idx_r <= idx_load_val_i;
        end
    end

    // ==========================================================
    // variable bank writes; type and bank fields never looked at
    always_comb begin
        bank_we    = 1'b0;
        bank_wdata = acc_r;
        if (state_r == AVX_EXEC && rep_r.status == avx_pkg::ST_OK && idx_ok) begin
            if (cmd.opcode == avx_pkg::OP_STORE_IMM) begin
                bank_we    = 1'b1;
                bank_wdata = cmd.value;
            end else if (cmd.opcode == avx_pkg::OP_STORE_ACC) begin
                bank_we    = 1'b1;
            end
        end
    end

    avx_var_bank u_bank (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .we_i    (bank_we),
        .waddr_i (idx_r[7:0]),
        .wdata_i (bank_wdata),
        .raddr_i (idx_r[7:0]),
        .rdata_o (bank_rdata)
    );

    // ==========================================================
    // axis parameter write for rotation
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            axis_wr_o  <= 1'b0;
            axis_o     <= '0;
            rot_down_o <= 1'b0;
        end else begin
            axis_wr_o <= 1'b0;
            if (state_r == AVX_EXEC && rep_r.status == avx_pkg::ST_OK
                && (cmd.opcode == avx_pkg::OP_ROT_DOWN || cmd.opcode == avx_pkg::OP_ROT_UP)) begin
                axis_wr_o    <= 1'b1;
                axis_o.mode  <= avx_pkg::AVX_MODE_VELOCITY;
                axis_o.param <= avx_pkg::AP_TARGET_VEL;
                axis_o.value <= acc_r;
                rot_down_o   <= (cmd.opcode == avx_pkg::OP_ROT_DOWN);
            end
        end
    end

    // ==========================================================
    // customer function hand-off
    assign cust_req_o = (state_r == AVX_CUST);
    assign cust_cmd_o = cmd;

    // ==========================================================
    // reply serialiser: host, module, status, opcode, value msb first, checksum
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_sum_r <= 8'h00;
        end else if (state_r == AVX_TX && tx_ready_i) begin
            tx_sum_r <= (cnt_r == 4'(avx_pkg::FRAME_BYTES - 1)) ? 8'h00 : tx_sum_r + tx_data_o;
        end
    end

    always_comb begin
        case (cnt_r)
            4'h0:    tx_data_o = avx_pkg::HOST_ADDR;
            4'h1:    tx_data_o = cmd.addr;
            4'h2:    tx_data_o = rep_r.status;
            4'h3:    tx_data_o = rep_r.opcode;
            4'h4:    tx_data_o = rep_r.value[31:24];
            4'h5:    tx_data_o = rep_r.value[23:16];
            4'h6:    tx_data_o = rep_r.value[15:8];
            4'h7:    tx_data_o = rep_r.value[7:0];
            default: tx_data_o = tx_sum_r;
        endcase
    end
endmodule
`default_nettype wire

// [avx_interp_props.sv]
// avx_interp_props: port-level checks on the interpreter
// assumes bind from the bench top, one clock domain
`default_nettype none
module avx_interp_props (
    // clock and reset
    input wire logic                  clk_i,
    input wire logic                  rstn_i,
    // byte streams
    input wire logic                  rx_valid_i,
    input wire logic [7:0]            rx_data_i,
    input wire logic                  rx_ready_o,
    input wire logic                  tx_valid_o,
    input wire logic [7:0]            tx_data_o,
    input wire logic                  tx_ready_i,
    // state, axis, customer
    input wire logic [31:0]           acc_o,
    input wire logic [31:0]           idx_o,
    input wire logic                  axis_wr_o,
    input wire avx_pkg::avx_axis_wr_t axis_o,
    input wire logic                  rot_down_o,
    input wire logic                  cust_req_o,
    input wire logic                  cust_done_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // frame tracking
    logic [3:0] cnt_r;
    logic [7:0] sum_r;
    logic [7:0] op_r;
    logic       last;
    logic       ok;
    assign last = rx_valid_i && rx_ready_o && cnt_r == 4'd8;
    assign ok   = rx_data_i == sum_r;
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= 4'd0;
            sum_r <= 8'h00;
            op_r  <= 8'h00;
        end else if (rx_valid_i && rx_ready_o) begin
            cnt_r <= last ? 4'd0 : cnt_r + 4'd1;
            sum_r <= last ? 8'h00 : sum_r + rx_data_i;
            if (cnt_r == 4'd1) op_r <= rx_data_i;
        end
    end
    // ==========================================================
    // checks
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_axis_fields: assert property (axis_wr_o |-> axis_o.value == acc_o
        && axis_o.mode == avx_pkg::AVX_MODE_VELOCITY && axis_o.param == avx_pkg::AP_TARGET_VEL)
        else $error("axis write fields wrong");
    a_rot_dir: assert property (axis_wr_o
        |=> rot_down_o == (op_r == avx_pkg::OP_ROT_DOWN))
        else $error("rotation direction wrong");
    a_rot_writes: assert property (last && ok && (op_r == avx_pkg::OP_ROT_DOWN
        || op_r == avx_pkg::OP_ROT_UP) |-> ##[1:3] axis_wr_o) else $error("no axis write");
    a_reply_due: assert property (last && (op_r < avx_pkg::OP_CUST_LO
        || op_r > avx_pkg::OP_CUST_HI) |-> ##[2:3] tx_valid_o) else $error("reply late");
    a_rx_closed: assert property (tx_valid_o |-> !rx_ready_o)
        else $error("receive open during reply");
    a_tx_holds: assert property (tx_valid_o && !tx_ready_i
        |=> tx_valid_o && $stable(tx_data_o))
        else $error("reply byte dropped");
    a_idx_ignored: assert property (last && ok && op_r == avx_pkg::OP_LOAD_VAR
        && idx_o[31:8] != 24'h0 |=> $stable(acc_o) [*4]) else $error("bad index loaded");
    a_cust_reply: assert property (cust_req_o && cust_done_i |=> tx_valid_o && !cust_req_o)
        else $error("customer reply late");
endmodule
`default_nettype wire

// [avx_host.sv]
// avx_host: host model, sends command frames and collects replies
// assumes the bench calls xfer one frame at a time after reset
`default_nettype none
module avx_host (
    // clock
    input  wire logic       clk_i,
    // command stream
    output logic            rx_valid_o,
    output logic      [7:0] rx_data_o,
    input  wire logic       rx_ready_i,
    // reply stream
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rep [9];
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
        tx_ready_o = 1'b0;
    end
    // ==========================================================
    // one frame out, one reply in; stall slows reply acceptance
    // a nonzero flip spoils the checksum on purpose
    task automatic xfer(input logic [7:0] op, input logic [31:0] v, input int stall,
                        input logic [7:0] flip);
        logic [7:0] b [9];
        b = '{8'h01, op, 8'h5a, 8'ha5, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
        for (int i = 0; i < 8; i++) b[8] += b[i];
        b[8] = b[8] ^ flip;
        for (int i = 0; i < 9; i++) begin
            rx_valid_o = 1'b1;
            rx_data_o  = b[i];
            while (rx_ready_i !== 1'b1) @(posedge clk_i) #1;
            @(posedge clk_i) #1;
        end
        rx_valid_o = 1'b0;
        rx_data_o  = ~b[8]; // released line must not look like live data
        for (int i = 0; i < 9; i++) begin
            if (stall > 0) begin
                tx_ready_o = 1'b0;
                repeat (stall) @(posedge clk_i) #1;
            end
            tx_ready_o = 1'b1;
            while (tx_valid_i !== 1'b1) @(posedge clk_i) #1;
            rep[i] = tx_data_i;
            @(posedge clk_i) #1;
        end
        tx_ready_o = 1'b0;
    endtask
endmodule
`default_nettype wire

// [accumulator_velocity_and_indexed_vars_tb.sv]
// accumulator_velocity_and_indexed_vars_tb: bench top for the interpreter
// assumes avx_host and avx_interp_props compiled first
`default_nettype none
module accumulator_velocity_and_indexed_vars_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // signals
    logic                  clk_i, rstn_i, rx_valid_i, rx_ready_o, tx_valid_o, tx_ready_i;
    logic                  acc_load_i, idx_load_i, axis_wr_o, rot_down_o, cust_req_o;
    logic                  cust_done_i, dn_seen;
    logic [7:0]            rx_data_i, tx_data_o;
    logic [31:0]           acc_load_val_i, idx_load_val_i, acc_o, idx_o, cust_value_i;
    avx_pkg::avx_axis_wr_t axis_o, ax_seen;
    avx_pkg::avx_cmd_t     cust_cmd_o;
    int                    mismatches = 0, compares = 0, ax_cnt = 0;
    avx_interp avx_interp_i (.clk_i, .rstn_i, .rx_valid_i, .rx_data_i, .rx_ready_o, .tx_valid_o,
        .tx_data_o, .tx_ready_i, .acc_load_i, .acc_load_val_i, .idx_load_i, .idx_load_val_i,
        .acc_o, .idx_o, .axis_wr_o, .axis_o, .rot_down_o, .cust_req_o, .cust_cmd_o,
        .cust_done_i, .cust_value_i);
    avx_host avx_host_i (.clk_i, .rx_valid_o(rx_valid_i), .rx_data_o(rx_data_i),
        .rx_ready_i(rx_ready_o), .tx_valid_i(tx_valid_o), .tx_data_i(tx_data_o),
        .tx_ready_o(tx_ready_i));
    always @(posedge clk_i) begin
        if (axis_wr_o === 1'b1) begin
            ax_seen = axis_o;
            dn_seen = rot_down_o;
            ax_cnt++;
        end
    end
    // ==========================================================
    // shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic load(input logic [31:0] acc, input logic [31:0] idx);
        {acc_load_i, idx_load_i, acc_load_val_i, idx_load_val_i} = {2'b11, acc, idx};
        @(posedge clk_i) #1;
        {acc_load_i, idx_load_i} = 2'b00;
    endtask
    task automatic cmd(input logic [7:0] op, input logic [31:0] v, input int stall);
        logic [7:0] s = 8'h00;
        avx_host_i.xfer(op, v, stall, 8'h00);
        for (int i = 0; i < 8; i++) s += avx_host_i.rep[i];
        check({avx_host_i.rep[0], avx_host_i.rep[1]}, {avx_pkg::HOST_ADDR, 8'h01});
        check({avx_host_i.rep[2], avx_host_i.rep[3]}, {avx_pkg::ST_OK, op});
        check(avx_host_i.rep[8], s);
    endtask
    task automatic vstep(input logic [31:0] idx, acc, input logic [7:0] op,
                         input logic [31:0] v, exp);
        load(acc, idx);
        cmd(op, v, int'(idx[0]));
        check(acc_o, exp);
        check(idx_o, idx);
    endtask
    // ==========================================================
    // scenarios
    task automatic t_rotate();
        for (int d = 0; d < 2; d++) begin
            load(32'h0001_2345 + d, 32'h0);
            cmd(d ? avx_pkg::OP_ROT_UP : avx_pkg::OP_ROT_DOWN, 32'hffff_ffff, d);
            check(ax_seen.mode, avx_pkg::AVX_MODE_VELOCITY);
            check(ax_seen.param, avx_pkg::AP_TARGET_VEL);
            check(ax_seen.value, 32'h0001_2345 + d);
            check(dn_seen, d == 0);
            check(ax_cnt, d + 1);
        end
    endtask
    task automatic t_vars();
        vstep(32'd255, 32'h0, avx_pkg::OP_STORE_IMM, 32'hcafe_0255, 32'h0);
        vstep(32'd255, 32'h0, avx_pkg::OP_LOAD_VAR, 32'h0, 32'hcafe_0255);
        vstep(32'd0, 32'h1357_9bdf, avx_pkg::OP_STORE_ACC, 32'h0, 32'h1357_9bdf);
        vstep(32'd0, 32'h0, avx_pkg::OP_LOAD_VAR, 32'h0, 32'h1357_9bdf);
        vstep(32'd256, 32'h0, avx_pkg::OP_STORE_IMM, 32'h0bad_0bad, 32'h0);
        vstep(32'd256, 32'h2468_ace0, avx_pkg::OP_LOAD_VAR, 32'h0, 32'h2468_ace0);
        vstep(32'hffff_ffff, 32'h2468_ace0, avx_pkg::OP_STORE_ACC, 32'h0, 32'h2468_ace0);
        vstep(32'hffff_ffff, 32'h0, avx_pkg::OP_LOAD_VAR, 32'h0, 32'h0);
        vstep(32'd0, 32'h0, avx_pkg::OP_LOAD_VAR, 32'h0, 32'h1357_9bdf);
        vstep(32'd255, 32'h0, avx_pkg::OP_LOAD_VAR, 32'h0, 32'hcafe_0255);
    endtask
    // spoiled frames must change nothing; opcode just past the customer range is unknown
    task automatic t_bad();
        load(32'h0000_0777, 32'd0);
        avx_host_i.xfer(avx_pkg::OP_ROT_UP, 32'h0, 0, 8'h01);
        check(avx_host_i.rep[2], avx_pkg::ST_BAD_CSUM);
        check(ax_cnt, 2);
        avx_host_i.xfer(avx_pkg::OP_STORE_IMM, 32'h0bad_0bad, 1, 8'h80);
        check(avx_host_i.rep[2], avx_pkg::ST_BAD_CSUM);
        avx_host_i.xfer(8'h48, 32'h0, 0, 8'h00);
        check(avx_host_i.rep[2], avx_pkg::ST_BAD_OP);
        vstep(32'd0, 32'h0, avx_pkg::OP_LOAD_VAR, 32'h0, 32'h1357_9bdf);
    endtask
    task automatic t_cust();
        for (int k = 0; k < 2; k++) begin
            logic [7:0] op;
            op = k ? avx_pkg::OP_CUST_HI : avx_pkg::OP_CUST_LO;
            fork
                cmd(op, 32'h0000_0abc, 1);
                begin
                    wait (cust_req_o === 1'b1);
                    #1 check(cust_cmd_o.opcode, op);
                    {cust_done_i, cust_value_i} = {1'b1, 32'h7e57_0000 + op};
                    @(posedge clk_i) #1 cust_done_i = 1'b0;
                end
            join
            check({avx_host_i.rep[4], avx_host_i.rep[5], avx_host_i.rep[6], avx_host_i.rep[7]},
                  32'h7e57_0000 + op);
        end
    endtask
    // ==========================================================
    // clock, reset, sequence, watchdog
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    initial begin
        {rstn_i, acc_load_i, idx_load_i, cust_done_i} = 4'b0000;
        {acc_load_val_i, idx_load_val_i, cust_value_i} = '0;
        repeat (6) @(posedge clk_i);
        #1 rstn_i = 1'b1;
        t_rotate();
        t_vars();
        t_bad();
        t_cust();
        finish_test();
    end
    // about 450 cycles expected; over a hundred times that means a hang
    initial begin
        #1ms;
        mismatches++;
        finish_test();
    end
endmodule
bind avx_interp avx_interp_props avx_interp_props_i (.clk_i, .rstn_i, .rx_valid_i, .rx_data_i,
    .rx_ready_o, .tx_valid_o, .tx_data_o, .tx_ready_i, .acc_o, .idx_o, .axis_wr_o, .axis_o,
    .rot_down_o, .cust_req_o, .cust_done_i);
`default_nettype wire
